// [driver_checker.sv]
// Port assertions for the dual chain driver core.
// Assumes pins move far slower than mclk; eight samples outlast the pin filter.
`include "dual_chain_map.svh"
module driver_checker #(
    parameter int CHAIN_LEN = `CHAIN_LEN_DEFAULT
) (
    // Clock and reset
    input wire logic                             mclk,
    input wire logic                             reset_n,
    // Pins and outputs
    input wire logic                             shift_clock,
    input wire logic                             transfer_gate,
    input wire logic                             force_on_n,
    input wire logic                             forward_shift,
    input wire dual_chain_pkg::serial_pins_s     serial_in,
    input wire dual_chain_pkg::serial_pins_s     serial_out,
    input wire dual_chain_pkg::serial_pins_s     serial_oe_n,
    input wire logic [`CHAIN_COUNT*CHAIN_LEN-1:0] channel_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_fwd_rise;
        (forward_shift && $stable(serial_in)) [*3] ##1 (forward_shift && $rose(shift_clock));
    endsequence
    property p_shift_in;
        s_fwd_rise |-> ##7 ((serial_out.a1 == $past(serial_in.a1, 7))
            && (serial_out.a2 == $past(serial_in.a2, 7)));
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift-in bit lost");
    property p_oe_fwd; forward_shift [*8] |=> serial_oe_n == 4'hc; endproperty
    a_oe_fwd: assert property (p_oe_fwd) else $error("forward pin roles wrong");
    property p_oe_rev; !forward_shift [*8] |=> serial_oe_n == 4'h3; endproperty
    a_oe_rev: assert property (p_oe_rev) else $error("reverse pin roles wrong");
    property p_force; !force_on_n [*8] |=> &channel_drive; endproperty
    a_force: assert property (p_force) else $error("forced channels not on");
    property p_hold; (!transfer_gate && force_on_n) [*8] |=> $stable(channel_drive); endproperty
    a_hold: assert property (p_hold) else $error("latched channels moved");
    property p_stands;
        (!shift_clock && $stable(forward_shift)) [*8] |=> $stable(serial_out);
    endproperty
    a_stands: assert property (p_stands) else $error("cascade output moved");
    property p_end_latch;
        (transfer_gate && force_on_n && !shift_clock) [*8] |=>
            channel_drive[CHAIN_LEN-1] == !serial_out.b1
            && channel_drive[2*CHAIN_LEN-1] == !serial_out.b2;
    endproperty
    a_end_latch: assert property (p_end_latch) else $error("last stage mismatch");
    property p_first_latch;
        (transfer_gate && force_on_n && !shift_clock) [*8] |=>
            channel_drive[0] == !serial_out.a1 && channel_drive[CHAIN_LEN] == !serial_out.a2;
    endproperty
    a_first_latch: assert property (p_first_latch) else $error("first stage mismatch");
endmodule

bind dual_chain_serial_to_parallel_driver driver_checker #(.CHAIN_LEN(CHAIN_LEN)) chk (
    .mclk(mclk), .reset_n(reset_n), .shift_clock(shift_clock),
    .transfer_gate(transfer_gate), .force_on_n(force_on_n), .forward_shift(forward_shift),
    .serial_in(serial_in), .serial_out(serial_out), .serial_oe_n(serial_oe_n),
    .channel_drive(channel_drive)
);

// [dual_chain_map.svh]
// Constants for the dual shift chain display driver core.
// Assumes it is included by bare name from every design file that needs it.
`ifndef DUAL_CHAIN_MAP_SVH
`define DUAL_CHAIN_MAP_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define CHAIN_LEN_DEFAULT     32
`define CHAIN_COUNT           2

// ----------------------------------------------------------------------------
// Pin sampling
// ----------------------------------------------------------------------------
`define PIN_SYNC_STAGES       3
`define CTRL_SYNC_WIDTH       8

// ----------------------------------------------------------------------------
// Reset values of the agreed pin levels, order {clk, gate, force_n, fwd, pins}
// ----------------------------------------------------------------------------
`define CTRL_SYNC_INIT        8'h30

`endif

// [dual_chain_pkg.sv]
// Types shared by the dual shift chain display driver core.
// Assumes dual_chain_map.svh holds the numeric constants.
package dual_chain_pkg;

    // ------------------------------------------------------------------------
    // Serial pin group: A side and B side of both chains
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic a1;
        logic a2;
        logic b1;
        logic b2;
    } serial_pins_s;

    // ------------------------------------------------------------------------
    // Control pins after sampling
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic shift_clock;
        logic transfer_gate;
        logic force_on_n;
        logic forward_shift;
    } ctrl_pins_s;

    typedef struct packed {
        ctrl_pins_s   ctrl;
        serial_pins_s pins;
    } sampled_pins_s;

endpackage

// [dual_chain_serial_to_parallel_driver.sv]
// Dual shift chain serial to parallel display driver core, 64 channels by default.
// Assumes all pins are asynchronous to mclk and the shift clock is far slower than mclk.
// Assumes the shift clock stays high and low for at least three mclk periods each,
// and that the data pins settle some mclk periods before the shift clock rises.
// Outputs follow the pins about five mclk periods late, which a panel never notices.
//
// Overview of operation
// RL1: There are two chains of 32 stages that advance together, taking two bits per shift edge.
// RL2: Both chains move one stage on every rising edge of the shift clock.
// RL3: A low direction input shifts in reverse, a high one shifts forward.
// RL4: The serial outputs always show the end stage of each chain for cascading.
// RL5: The transfer gate and the force-on input never stall or change the chains.
// RL6: While the transfer gate is high the 64 holding latches follow the chains.
// RL7: While the transfer gate is low the latches keep their values.
// RL8: The first chain feeds channels 1 to 32 and the second chain channels 33 to 64.
// RL9: Channel 1 is fed from stage one of the first chain through its latch and the blanking.
// RL10: Unforced, each channel shows the inverse of its stored bit, so a stored low is on.
// RL11: A low force-on input turns every channel on; a high one lets the latches through.
// RL12: Forward uses the A pins as inputs and the B pins as outputs; reverse swaps them.
`include "dual_chain_map.svh"

module dual_chain_serial_to_parallel_driver #(
    parameter int CHAIN_LEN = `CHAIN_LEN_DEFAULT
) (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    // Control pins
    input  wire logic                          shift_clock,
    input  wire logic                          transfer_gate,
    input  wire logic                          force_on_n,
    input  wire logic                          forward_shift,
    // Two-way serial pins
    input  wire dual_chain_pkg::serial_pins_s  serial_in,
    output dual_chain_pkg::serial_pins_s       serial_out,
    output dual_chain_pkg::serial_pins_s       serial_oe_n,
    // Channel outputs, bit 0 is channel 1, high means on
    output logic [`CHAIN_COUNT*CHAIN_LEN-1:0]  channel_drive
);

    localparam int CHANNELS = `CHAIN_COUNT * CHAIN_LEN;

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    // Shorter chains leave no room for a separate first and last stage
    if (CHAIN_LEN < 2) begin : g_bad_chain_len
        $error("CHAIN_LEN must be at least 2");
    end
    // The latch word and the cascade pins are built for exactly two chains
    if (`CHAIN_COUNT != 2) begin : g_bad_chain_count
        $error("the latch word is built for two chains");
    end
    if ($bits(dual_chain_pkg::sampled_pins_s) != `CTRL_SYNC_WIDTH) begin : g_bad_sync_width
        $error("sampled pin group and sampler width differ");
    end

    // ------------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------------
    dual_chain_pkg::sampled_pins_s raw_pins;
    dual_chain_pkg::sampled_pins_s sampled;
    logic [`CTRL_SYNC_WIDTH-1:0]   sampled_bits;

    // Packing through the struct ties the pin order to the sampled view
    always_comb begin
        raw_pins.ctrl.shift_clock   = shift_clock;
        raw_pins.ctrl.transfer_gate = transfer_gate;
        raw_pins.ctrl.force_on_n    = force_on_n;
        raw_pins.ctrl.forward_shift = forward_shift;
        raw_pins.pins               = serial_in;
    end

    pin_sampler #(
        .WIDTH (`CTRL_SYNC_WIDTH),
        .INIT  (`CTRL_SYNC_INIT)
    ) u_pin_sampler (
        .mclk    (mclk),
        .reset_n (reset_n),
        .pin_in  (raw_pins),
        .level   (sampled_bits)
    );

    assign sampled = dual_chain_pkg::sampled_pins_s'(sampled_bits);

    // ------------------------------------------------------------------------
    // Chain step
    // ------------------------------------------------------------------------
    // Index 0 is stage one, next to the A pin; index CHAIN_LEN-1 is next to B
    function automatic logic [CHAIN_LEN-1:0] chain_step(
        input logic [CHAIN_LEN-1:0] chain,
        input logic                 forward,
        input logic                 from_a,
        input logic                 from_b
    );
        if (forward) begin
            chain_step = {chain[CHAIN_LEN-2:0], from_a};    // [RL3]
        end else begin
            chain_step = {from_b, chain[CHAIN_LEN-1:1]};    // [RL3]
        end
    endfunction

    // ------------------------------------------------------------------------
    // Shift chains
    // ------------------------------------------------------------------------
    logic                 clock_seen;
    logic                 next_clock_seen;
    logic                 shift_edge;
    logic [CHAIN_LEN-1:0] first_chain;
    logic [CHAIN_LEN-1:0] second_chain;
    logic [CHAIN_LEN-1:0] next_first_chain;
    logic [CHAIN_LEN-1:0] next_second_chain;

    // Pins pass equal sampling depth, so data seen here predates the edge
    always_comb begin
        next_clock_seen   = sampled.ctrl.shift_clock;
        shift_edge        = sampled.ctrl.shift_clock & ~clock_seen;    // [RL2]
        next_first_chain  = first_chain;
        next_second_chain = second_chain;
        // Gate and force-on take no part here
        if (shift_edge) begin    // [RL5]
            next_first_chain  = chain_step(first_chain, sampled.ctrl.forward_shift,
                                           sampled.pins.a1, sampled.pins.b1);    // [RL1]
            next_second_chain = chain_step(second_chain, sampled.ctrl.forward_shift,
                                           sampled.pins.a2, sampled.pins.b2);    // [RL1]
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clock_seen   <= 1'b0;
            // Known start only; the image means nothing until a full frame arrives
            first_chain  <= '0;
            second_chain <= '0;
        end else begin
            clock_seen   <= next_clock_seen;
            first_chain  <= next_first_chain;
            second_chain <= next_second_chain;
        end
    end

    // ------------------------------------------------------------------------
    // Holding latches and channel drive
    // ------------------------------------------------------------------------
    logic [CHANNELS-1:0] held;
    logic [CHANNELS-1:0] next_held;
    logic [CHANNELS-1:0] next_channel_drive;

    // Force-on leaves the latches alone, so releasing it brings back the stored image
    function automatic logic [CHANNELS-1:0] drive_levels(
        input logic [CHANNELS-1:0] stored,
        input logic                force_n
    );
        if (!force_n) begin
            drive_levels = '1;    // [RL11]
        end else begin
            drive_levels = ~stored;    // [RL10]
        end
    endfunction

    always_comb begin
        next_held = held;    // [RL7]
        if (sampled.ctrl.transfer_gate) begin
            next_held = {next_second_chain, next_first_chain};    // [RL6] [RL8] [RL9]
        end
        next_channel_drive = drive_levels(next_held, sampled.ctrl.force_on_n);
    end

    // Latches reset to all ones so the channels start off unless forced
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            held          <= '1;
            channel_drive <= '0;
        end else begin
            held          <= next_held;
            channel_drive <= next_channel_drive;
        end
    end

    // ------------------------------------------------------------------------
    // Serial pin direction and cascade outputs
    // ------------------------------------------------------------------------
    dual_chain_pkg::serial_pins_s next_serial_out;
    dual_chain_pkg::serial_pins_s next_serial_oe_n;

    // Both ends are always computed; the direction only picks which side drives
    function automatic dual_chain_pkg::serial_pins_s chain_ends(
        input logic [CHAIN_LEN-1:0] first,
        input logic [CHAIN_LEN-1:0] second
    );
        dual_chain_pkg::serial_pins_s ends;
        ends.a1 = first[0];                // [RL4]
        ends.a2 = second[0];               // [RL4]
        ends.b1 = first[CHAIN_LEN-1];      // [RL4]
        ends.b2 = second[CHAIN_LEN-1];     // [RL4]
        return ends;
    endfunction

    // Low enable drives; one decode keeps both sides from ever driving together
    function automatic dual_chain_pkg::serial_pins_s pin_roles(
        input logic forward
    );
        dual_chain_pkg::serial_pins_s roles;
        roles.a1 = forward;     // [RL12]
        roles.a2 = forward;     // [RL12]
        roles.b1 = ~forward;    // [RL12]
        roles.b2 = ~forward;    // [RL12]
        return roles;
    endfunction

    always_comb begin
        next_serial_out  = chain_ends(next_first_chain, next_second_chain);
        next_serial_oe_n = pin_roles(sampled.ctrl.forward_shift);
    end

    // Out of reset the device shifts forward, so only the B side drives
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            serial_out  <= '0;
            serial_oe_n <= 4'hc;
        end else begin
            serial_out  <= next_serial_out;
            serial_oe_n <= next_serial_oe_n;
        end
    end

endmodule

// [dual_chain_serial_to_parallel_driver_tb_top.sv]
// Self-checking bench for the dual chain driver core.
// Assumes serial_controller.sv and the checker are compiled first.
`include "dual_chain_map.svh"
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", what, exp, got); end end
module dual_chain_serial_to_parallel_driver_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         LEN = `CHAIN_LEN_DEFAULT;
    localparam logic [2:0] CORNER [6] = '{3'h3, 3'h7, 3'h0, 3'h2, 3'h6, 3'h4};
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic transfer_gate = 1'b0;
    logic force_on_n = 1'b1;
    logic forward_shift = 1'b1;
    logic shift_clock;
    dual_chain_pkg::serial_pins_s ctl_drive, serial_in, serial_out, serial_oe_n;
    logic [2*LEN-1:0] channel_drive;
    logic [LEN-1:0]   ref1 = '0;
    logic [LEN-1:0]   ref2 = '0;
    logic [2*LEN-1:0] ref_latch = '1;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 mclk = ~mclk;
    // Pins the device drives take its level, the rest the controller's
    assign serial_in = (serial_oe_n & ctl_drive) | (~serial_oe_n & serial_out);
    serial_controller ctl (.mclk(mclk), .forward(forward_shift), .shift_clock(shift_clock),
        .drive(ctl_drive));
    dual_chain_serial_to_parallel_driver #(.CHAIN_LEN(LEN)) uut (.mclk(mclk),
        .reset_n(reset_n), .shift_clock(shift_clock), .transfer_gate(transfer_gate),
        .force_on_n(force_on_n), .forward_shift(forward_shift), .serial_in(serial_in),
        .serial_out(serial_out), .serial_oe_n(serial_oe_n), .channel_drive(channel_drive));
    function automatic logic [LEN-1:0] next_chain(logic [LEN-1:0] c, logic d, logic fwd);
        return fwd ? {c[LEN-2:0], d} : {d, c[LEN-1:1]};
    endfunction
    function automatic logic [2*LEN-1:0] exp_drive();
        return force_on_n ? ~ref_latch : '1;
    endfunction
    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check_all();
        logic [1:0] exp_end;
        logic [1:0] got_end;
        // Look away from the edge that launches the outputs
        @(negedge mclk);
        exp_end = forward_shift ? {ref1[LEN-1], ref2[LEN-1]} : {ref1[0], ref2[0]};
        got_end = forward_shift ? {serial_out.b1, serial_out.b2} : {serial_out.a1, serial_out.a2};
        `CHK("channel_drive", exp_drive(), channel_drive)
        `CHK("serial_oe_n", forward_shift ? 4'hc : 4'h3, serial_oe_n)
        `CHK("cascade", exp_end, got_end)
    endtask
    task automatic set_ctrl(input logic g, input logic f, input logic d);
        @(posedge mclk);
        transfer_gate <= g;
        force_on_n <= f;
        forward_shift <= d;
        repeat (10) @(posedge mclk);
        if (g) ref_latch = {ref2, ref1};
        check_all();
    endtask
    task automatic shift_one(input int gap);
        logic d1;
        logic d2;
        d1 = 1'($urandom);
        d2 = 1'($urandom);
        ctl.send(d1, d2, gap);
        ref1 = next_chain(ref1, d1, forward_shift);
        ref2 = next_chain(ref2, d2, forward_shift);
        if (transfer_gate) ref_latch = {ref2, ref1};
        check_all();
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Corners first (full fill held, transparent, forced reverse, unforced reverse,
    // transparent reverse, forced transparent), then random
    initial begin
        void'($urandom(4));
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (8) @(posedge mclk);
        check_all();
        for (int p = 0; p < 16; p++) begin
            logic [2:0] c;
            int         n;
            c = (p < 6) ? CORNER[p] : 3'($urandom);
            set_ctrl(c[2], c[1], c[0]);
            n = (p == 0) ? LEN + 1 : 1 + $urandom_range(7);
            for (int i = 0; i < n; i++) shift_one($urandom_range(3));
        end
        print_verdict();
    end
endmodule

// [pin_sampler.sv]
// Three-stage pin sampler with an agreed-level filter.
// Assumes asynchronous pins; the agreed level moves only when stages two and three match.
`include "dual_chain_map.svh"

module pin_sampler #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Pins and filtered levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level
);

    if (`PIN_SYNC_STAGES != 3) begin : g_bad_stages
        $error("pin_sampler is built for three stages");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sampler needs at least one pin");
    end

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // Stage one feeds stage two only; the filter looks at two and three
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            level  <= INIT;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

endmodule

// [serial_controller.sv]
// Display controller model that streams two bits per shift clock pulse.
// Assumes the bench resolves each serial pin from the device's output enables.
module serial_controller (
    // Clock and direction
    input  wire logic                    mclk,
    input  wire logic                    forward,
    // Pins toward the device
    output logic                         shift_clock,
    output dual_chain_pkg::serial_pins_s drive
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        shift_clock = 1'b0;
        drive = '0;
    end
    // Far side carries the inverse, so a stale level never passes for data
    task automatic send(input logic d1, input logic d2, input int gap);
        @(posedge mclk);
        drive <= forward ? {d1, d2, ~d1, ~d2} : {~d1, ~d2, d1, d2};
        repeat (5) @(posedge mclk);
        shift_clock <= 1'b1;
        repeat (4 + gap) @(posedge mclk);
        shift_clock <= 1'b0;
        repeat (4 + gap) @(posedge mclk);
    endtask
endmodule
